/* File: common/hbq_consts.svh */
`ifndef HBQ_CONSTS_SVH
`define HBQ_CONSTS_SVH
`define HBQ_STATUS_ADDR      16'h9ae8
`define HBQ_PIXEL_ADDR       16'he2e8
`define HBQ_SUBSYS_ADDR      16'h42e8
`define HBQ_SUBCTRL_ADDR     16'h42e8
`define HBQ_QUEUE_BASE       16'h8000
`define HBQ_IO_LOW_MASK      16'h03ff
`define HBQ_IO_LOW_VAL       16'h02e8
`define HBQ_BUSY_BIT         9
`define HBQ_RDY_BIT          8
`define HBQ_TIMEOUT_NS       4000
`define HBQ_CLK_NS           8
`define HBQ_TIMEOUT_CYC      ((`HBQ_TIMEOUT_NS + `HBQ_CLK_NS - 1) / `HBQ_CLK_NS)
`define HBQ_ROM_MC_BASE      5'h18
`define HBQ_ROM_ISA_BASE     5'h19
`define HBQ_PIX_MEM_PAGE     3'h5
`endif

/* File: common/hbq_pkg.sv */
package hbq_pkg;
   typedef enum logic [1:0] {
      HBQ_MODE_MC   = 2'b00,
      HBQ_MODE_ISA  = 2'b01,
      HBQ_MODE_UISA = 2'b10
   } hbq_mode_e;
   typedef enum logic [1:0] {
      HBQ_IDLE    = 2'b00,
      HBQ_STRETCH = 2'b01,
      HBQ_DONE    = 2'b10
   } hbq_cyc_e;
endpackage : hbq_pkg

/* File: logic/hbq_queue_mem.sv */
module hbq_queue_mem #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             mclk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output      logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : hbq_queue_mem

/* File: logic/hbq_sync.sv */
module hbq_sync #(
   parameter int N = 1
) (
   input  wire logic         mclk,
   input  wire logic [N-1:0] d,
   output      logic [N-1:0] q
);
   // no reset: the chain keeps tracking the pins through reset, so the
   // straps and idle strobe levels are already settled at release
   logic [N-1:0] meta;

   always_ff @(posedge mclk) begin
      meta <= d;
      q    <= meta;
   end
endmodule : hbq_sync

/* File: logic/hbq_host_port.sv */
`include "hbq_consts.svh"
module hbq_host_port
   import hbq_pkg::*;
#(
   parameter int TIMEOUT_CYC = `HBQ_TIMEOUT_CYC,
   parameter int QDEPTH      = 16
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        busTypeSelect_n,
   input  wire logic        unlatchedModeStrap,
   input  wire logic [23:0] addrPin,
   input  wire logic        cmdStrobe_n,
   input  wire logic        ioRd_n,
   input  wire logic        ioWr_n,
   input  wire logic        memRd_n,
   input  wire logic        memWr_n,
   input  wire logic        addrLatchEn,
   input  wire logic [15:0] dataIn,
   output      logic [15:0] dataOut,
   output      logic        dataOe,
   output      logic        chanReady,
   output      logic        zeroWait_n,
   output      logic        romSel_n,
   output      logic        memCs16_n,
   output      logic        irqOut,
   output      logic        irqOe,
   input  wire logic        engineDone,
   input  wire logic        engineTake,
   input  wire logic        readDataValid,
   input  wire logic [15:0] readData,
   input  wire logic        scissorHit,
   input  wire logic        scissorCmd,
   input  wire logic        depthFourOrEight,
   input  wire logic        vblank,
   output      logic        paramValid,
   output      logic [3:0]  paramSel,
   output      logic [15:0] paramData,
   output      logic        engineHalt
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   localparam int NS = 8;
   logic [NS-1:0] pinRaw;
   logic [NS-1:0] pinSync;
   logic [23:0]   addrSync;
   logic [15:0]   dataSync;
   assign pinRaw = {busTypeSelect_n, unlatchedModeStrap, cmdStrobe_n, ioRd_n,
                    ioWr_n, memRd_n, memWr_n, addrLatchEn};
   logic          vblankS;
   logic [4:0]    strbDly;
   hbq_sync #(.N(NS)) uPins (.mclk(mclk), .d(pinRaw), .q(pinSync));
   hbq_sync #(.N(24)) uAddr (.mclk(mclk), .d(addrPin), .q(addrSync));
   hbq_sync #(.N(16)) uData (.mclk(mclk), .d(dataIn), .q(dataSync));
   // blanking comes from the video clock, so it is synchronised like a pin
   hbq_sync #(.N(1))  uVbl  (.mclk(mclk), .d(vblank), .q(vblankS));

   wire isaSel_n = pinSync[7];
   wire strapS   = pinSync[6];
   wire aleS     = pinSync[0];
   // strobes lag the synchronised address by one cycle, so the decode
   // never sees the address left over from the previous access
   wire cmdS_n   = strbDly[4];
   wire iorS_n   = strbDly[3];
   wire iowS_n   = strbDly[2];
   wire memrS_n  = strbDly[1];
   wire memwS_n  = strbDly[0];

   // ****************************************
   // bus mode and address capture
   // ****************************************
   hbq_mode_e mode;
   logic      strapTaken;
   logic [23:0] addrHold;

   always_ff @(posedge mclk) begin
      if (rst) begin
         mode       <= HBQ_MODE_MC;
         strapTaken <= 1'b0;
      end else if (!strapTaken) begin
         // strap caught once after release; a moving pin later cannot flip mode
         strapTaken <= 1'b1;
         if (!strapS) mode <= HBQ_MODE_UISA;
         else if (!isaSel_n) mode <= HBQ_MODE_ISA;
         else mode <= HBQ_MODE_MC;
      end
   end

   wire isMc   = (mode == HBQ_MODE_MC);
   wire isUisa = (mode == HBQ_MODE_UISA);
   // the delayed strobe is the previous value of the synchronised one
   wire cmdFall = cmdS_n && !pinSync[5];

   always_ff @(posedge mclk) begin
      if (rst) begin
         strbDly  <= 5'h1f;
         addrHold <= 24'h000000;
      end else begin
         strbDly <= pinSync[5:1];
         if (isMc && cmdFall) addrHold <= addrSync;
         // latch stays open while the address latch enable is high
         else if (isUisa && aleS) addrHold[23:17] <= addrSync[23:17];
         if (!isMc) addrHold[16:0] <= addrSync[16:0];
         if (mode == HBQ_MODE_ISA) addrHold[23:17] <= 7'h00;
      end
   end

   // ****************************************
   // decode
   // ****************************************
   wire ioRead  = isMc ? (!cmdS_n && !iorS_n) : !iorS_n;
   wire ioWrite = isMc ? (!cmdS_n && !iowS_n) : !iowS_n;
   wire memRead = !memrS_n;
   wire ioMine  = ((addrHold[15:0] & `HBQ_IO_LOW_MASK) == `HBQ_IO_LOW_VAL)
                  && (addrHold[23:16] == 8'h00);
   // register select bits 13:10 are not part of the queue match
   wire queueHit = ioMine && addrHold[15];
   wire statusHit = ioMine && (addrHold[15:0] == `HBQ_STATUS_ADDR);
   wire pixIoHit = ioMine && addrHold[15:0] == `HBQ_PIXEL_ADDR;
   wire subHit = ioMine && addrHold[15:0] == `HBQ_SUBSYS_ADDR;
   wire pixMemHit = isUisa && addrHold[19:17] == `HBQ_PIX_MEM_PAGE
                    && addrHold[23:20] == 4'h0 && !addrHold[16];
   wire [4:0] romPage = isMc ? `HBQ_ROM_MC_BASE : `HBQ_ROM_ISA_BASE;
   wire romHit = (addrHold[19:15] == romPage) && addrHold[23:20] == 4'h0;

   assign romSel_n  = !(romHit && memRead);
   assign memCs16_n = 1'b1;

   wire qWriteReq = (ioWrite && queueHit) || (isUisa && !memwS_n && pixMemHit);
   wire pixReadReq = (ioRead && pixIoHit) || (isUisa && memRead && pixMemHit);

   // ****************************************
   // write queue
   // ****************************************
   logic [4:0]  count;
   logic [3:0]  wrPtr;
   logic [3:0]  rdPtr;
   logic [19:0] qOut;
   logic        cycleDone;
   logic        badFlag;
   logic        execBusy;
   logic        outValid;
   hbq_cyc_e    cyc;
   logic [15:0] tmo;

   wire qFull  = (count == 5'(QDEPTH));
   wire qEmpty = (count == 5'd0);
   wire push   = qWriteReq && cyc != HBQ_DONE && !qFull && !cycleDone;
   // a new parameter is released only between drawing operations
   wire pop    = !qEmpty && !outValid && !badFlag && !execBusy;

   hbq_queue_mem #(.WIDTH(20), .DEPTH(16), .AW(4)) uMem (
      .mclk(mclk), .we(push), .waddr(wrPtr),
      .wdata({pixMemHit ? 4'he : addrHold[13:10], dataSync}),
      .raddr(rdPtr), .rdata(qOut));

   always_ff @(posedge mclk) begin
      if (rst) begin
         count    <= 5'd0;
         wrPtr    <= 4'h0;
         rdPtr    <= 4'h0;
         outValid <= 1'b0;
         execBusy <= 1'b0;
      end else begin
         count <= count + 5'(push) - 5'(pop);
         if (push) wrPtr <= wrPtr + 4'h1;
         if (pop) rdPtr <= rdPtr + 4'h1;
         outValid <= pop;
         if (engineTake) execBusy <= 1'b1;
         else if (engineDone) execBusy <= 1'b0;
      end
   end

   assign paramValid = outValid;
   assign paramSel   = qOut[19:16];
   assign paramData  = qOut[15:0];
   assign engineHalt = badFlag;

   // ****************************************
   // one word read queue
   // ****************************************
   logic        rdFull;
   logic [15:0] rdWord;
   wire rdTake = pixReadReq && rdFull && cyc != HBQ_DONE && !cycleDone;
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdFull <= 1'b0;
         rdWord <= 16'h0000;
      end else if (readDataValid && !rdFull) begin
         rdFull <= 1'b1;
         rdWord <= readData;
      end else if (rdTake) begin
         rdFull <= 1'b0;
      end
   end

   // ****************************************
   // cycle stretch and timeout
   // ****************************************
   wire stallCond = (qWriteReq && qFull) || (pixReadReq && !rdFull);
   wire anyCmd = ioRead || ioWrite || memRead || !memwS_n;
   wire timedOut = (cyc == HBQ_STRETCH) && tmo == 16'(TIMEOUT_CYC - 1);

   always_ff @(posedge mclk) begin
      if (rst) begin
         cyc       <= HBQ_IDLE;
         tmo       <= 16'h0000;
         cycleDone <= 1'b0;
      end else begin
         unique case (cyc)
            HBQ_IDLE: begin
               tmo <= 16'h0000;
               if (stallCond && !cycleDone) cyc <= HBQ_STRETCH;
               if (push || rdTake) cycleDone <= 1'b1;
            end
            HBQ_STRETCH: begin
               tmo <= tmo + 16'h0001;
               if (!stallCond) cyc <= HBQ_IDLE;
               else if (timedOut) cyc <= HBQ_DONE;
            end
            HBQ_DONE: begin
               if (!anyCmd) cyc <= HBQ_IDLE;
            end
            default: cyc <= HBQ_IDLE;
         endcase
         if (!anyCmd) cycleDone <= 1'b0;
      end
   end

   assign chanReady  = !(cyc == HBQ_STRETCH || (cyc == HBQ_IDLE && stallCond
                         && !cycleDone));
   logic zwsActive;
   assign zwsActive  = isUisa && pixMemHit && !stallCond && (memRead || !memwS_n);
   assign zeroWait_n = !zwsActive;

   // ****************************************
   // interrupts
   // ****************************************
   logic [3:0] irqEn;
   logic [3:0] irqFlag;
   logic [3:0] condPrev;
   logic [3:0] irqPend;
   logic       wrPrev;
   wire idle = !execBusy && qEmpty && !outValid;
   wire [3:0] cond = {idle,
                      timedOut,
                      scissorHit && scissorCmd && depthFourOrEight,
                      vblankS};
   wire subWrite = ioWrite && subHit && !wrPrev;
   wire [3:0] clrBits = subWrite ? dataSync[3:0] : 4'h0;

   always_ff @(posedge mclk) begin
      if (rst) begin
         irqEn    <= 4'h0;
         irqFlag  <= 4'h0;
         condPrev <= 4'h0;
         irqPend  <= 4'h0;
         wrPrev   <= 1'b0;
         badFlag  <= 1'b0;
      end else begin
         wrPrev   <= ioWrite && subHit;
         condPrev <= cond;
         if (subWrite) irqEn <= dataSync[11:8];
         // set beats clear when both land together
         irqFlag <= (irqFlag & ~clrBits) | cond;
         irqPend <= (irqPend & ~clrBits) | (cond & ~condPrev & irqEn);
         if (timedOut) badFlag <= 1'b1;
         else if (clrBits[2]) badFlag <= 1'b0;
      end
   end

   wire irqActive = |irqPend;
   // in unlatched mode with zero wait in use the shared pin carries zero wait
   always_comb begin
      if (isMc) begin
         irqOut = 1'b0;
         irqOe  = irqActive;
      end else if (isUisa && zwsActive) begin
         irqOut = 1'b0;
         irqOe  = 1'b0;
      end else begin
         irqOut = irqActive;
         irqOe  = |irqEn;
      end
   end

   // ****************************************
   // read data
   // ****************************************
   wire [15:0] statusWord = {6'h00, !idle || !qEmpty, rdFull,
                             (count == 5'd16) ? 8'hff :
                             (count >= 5'd9) ? 8'h7f >> (5'd15 - count) & 8'h7f :
                             (count >= 5'd1) ? 8'h01 : 8'h00};
   always_ff @(posedge mclk) begin
      if (rst) begin
         dataOut <= 16'h0000;
         dataOe  <= 1'b0;
      end else begin
         dataOe <= (ioRead && (statusHit || pixIoHit || subHit))
                   || (isUisa && memRead && pixMemHit);
         if (ioRead && statusHit) dataOut <= statusWord;
         else if (pixReadReq) dataOut <= rdWord;
         else if (ioRead && subHit) dataOut <= {4'h0, irqEn, 4'h0, irqFlag};
      end
   end
endmodule : hbq_host_port

/* File: tb/hbq_host_model.sv */
module hbq_host_model (
   input  wire logic        mclk,
   input  wire logic        chanReady,
   input  wire logic [15:0] dataOut,
   output      logic [23:0] addrPin,
   output      logic        cmdStrobe_n,
   output      logic        ioRd_n,
   output      logic        ioWr_n,
   output      logic        memRd_n,
   output      logic        memWr_n,
   output      logic        addrLatchEn,
   output      logic [15:0] dataIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // host io cycle
   // ****
   initial begin
      {addrPin, dataIn} = '0;
      {cmdStrobe_n, ioRd_n, ioWr_n, memRd_n, memWr_n} = 5'h1f;
      addrLatchEn = 1'b0;
   end
   // w counts stretched cycles; 99 means the device never ended the cycle
   task automatic io(input logic wr, input logic [23:0] a, input logic [15:0] d,
                     output logic [15:0] q, output int w);
      logic mem;
      w = 0;
      // an upper address byte marks a memory cycle
      mem = |a[23:16];
      @(posedge mclk);
      addrPin <= a;
      dataIn <= d;
      addrLatchEn <= 1'b1;
      cmdStrobe_n <= 1'b0;
      if (mem && wr) memWr_n <= 1'b0;
      else if (mem) memRd_n <= 1'b0;
      else if (wr) ioWr_n <= 1'b0;
      else ioRd_n <= 1'b0;
      repeat (5) @(posedge mclk);
      while (!chanReady && w < 99) begin
         w++;
         @(posedge mclk);
      end
      q = dataOut;
      {cmdStrobe_n, ioRd_n, ioWr_n, memRd_n, memWr_n} <= 5'h1f;
      addrLatchEn <= 1'b0;
      // released lines must not keep the old value
      addrPin <= ~addrPin;
      dataIn <= ~d;
      // strobes stay high long enough for the synchroniser to see the gap
      repeat (4) @(posedge mclk);
   endtask : io
endmodule : hbq_host_model

/* File: tb/hbq_host_port_properties.sv */
module hbq_port_chk #(
   parameter int TIMEOUT_CYC = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic busTypeSelect_n,
   input wire logic unlatchedModeStrap,
   input wire logic ioRd_n,
   input wire logic ioWr_n,
   input wire logic memRd_n,
   input wire logic memWr_n,
   input wire logic chanReady,
   input wire logic zeroWait_n,
   input wire logic memCs16_n,
   input wire logic irqOut,
   input wire logic irqOe,
   input wire logic dataOe,
   input wire logic paramValid,
   input wire logic engineHalt
);
   timeunit 1ns;
   timeprecision 1ps;
   int stallCnt;
   int busAge;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ****
   // helper counters
   // ****
   always_ff @(posedge mclk) begin
      if (rst || chanReady) stallCnt <= 0;
      else stallCnt <= stallCnt + 1;
   end
   // saturates so a long idle spell cannot wrap
   always_ff @(posedge mclk) begin
      if (!(ioRd_n && ioWr_n && memRd_n && memWr_n)) busAge <= 0;
      else if (busAge < 15) busAge <= busAge + 1;
   end
   // ****
   // properties
   // ****
   chk_no_memcs16: assert property (memCs16_n)
      else $error("16-bit memory select driven");
   chk_reset_outs: assert property ($fell(rst) |-> chanReady && !dataOe && !paramValid && !irqOe)
      else $error("outputs not idle after reset");
   chk_stall_bound: assert property (stallCnt <= TIMEOUT_CYC + 2)
      else $error("stretch outlived the timeout");
   chk_stall_cause: assert property (!chanReady |-> busAge <= 4)
      else $error("stretch with no access");
   chk_halt_quiet: assert property (engineHalt ##1 engineHalt |-> !paramValid)
      else $error("queue drained while halted");
   chk_halt_clear: assert property ($fell(engineHalt) |-> busAge <= 5)
      else $error("halt dropped without a host write");
   chk_mc_irq_low: assert property (busTypeSelect_n && unlatchedModeStrap && irqOe |-> !irqOut)
      else $error("mc irq driven high");
   chk_zws_mode: assert property (unlatchedModeStrap |-> zeroWait_n)
      else $error("zero wait outside unlatched mode");
   cover property (!chanReady ##1 chanReady);
   cover property ($rose(engineHalt));
   cover property ($rose(irqOe));
   cover property (!zeroWait_n);
endmodule : hbq_port_chk
bind hbq_host_port hbq_port_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (.mclk, .rst,
   .busTypeSelect_n, .unlatchedModeStrap, .ioRd_n, .ioWr_n, .memRd_n, .memWr_n,
   .chanReady, .zeroWait_n, .memCs16_n, .irqOut, .irqOe, .dataOe, .paramValid, .engineHalt);

/* File: tb/tb_host_bus_queue_irq.sv */
module tb_host_bus_queue_irq;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TO = 8;
   logic        mclk = 1'b0, rst = 1'b1, busTypeSelect_n = 1'b1, vblank = 1'b0;
   logic        unlatchedModeStrap = 1'b1, scissorHit = 1'b0, scissorCmd = 1'b0;
   logic        engineDone = 1'b0, engineTake = 1'b0, readDataValid = 1'b0;
   logic [23:0] addrPin;
   logic        cmdStrobe_n, ioRd_n, ioWr_n, memRd_n, memWr_n, addrLatchEn, paramValid;
   logic        dataOe, chanReady, zeroWait_n, romSel_n, memCs16_n, irqOut, irqOe, engineHalt;
   logic [15:0] dataIn, dataOut, paramData, pData, q, readData = '0;
   logic [3:0]  paramSel, pSel;
   int          error_cnt = 0, check_count = 0, pCnt = 0, w, zwsCnt = 0, romCnt = 0;

   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      if (paramValid === 1'b1) begin
         pCnt++;
         pSel = paramSel;
         pData = paramData;
      end
      if (zeroWait_n === 1'b0) zwsCnt++;
      if (romSel_n === 1'b0) romCnt++;
   end

   hbq_host_port #(.TIMEOUT_CYC(TO)) dut_u (
      .mclk, .rst, .busTypeSelect_n, .unlatchedModeStrap, .addrPin, .cmdStrobe_n,
      .ioRd_n, .ioWr_n, .memRd_n, .memWr_n, .addrLatchEn, .dataIn, .dataOut, .dataOe,
      .chanReady, .zeroWait_n, .romSel_n, .memCs16_n, .irqOut, .irqOe, .engineDone,
      .engineTake, .readDataValid, .readData, .scissorHit, .scissorCmd,
      .depthFourOrEight(1'b1), .vblank, .paramValid, .paramSel, .paramData, .engineHalt);
   hbq_host_model hm_u (.mclk, .chanReady, .dataOut, .addrPin, .cmdStrobe_n, .ioRd_n,
      .ioWr_n, .memRd_n, .memWr_n, .addrLatchEn, .dataIn);

   // ****
   // helpers
   // ****
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("ERROR t=%0t %s", $time, msg);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d);
      mbus(wr, {8'h00, a}, d);
   endtask : bus
   task automatic mbus(input logic wr, input logic [23:0] a, input logic [15:0] d);
      hm_u.io(wr, a, d, q, w);
      if (w >= 99) begin
         chk(1'b0, "bus cycle hung");
         results;
      end
   endtask : mbus
   task automatic engPulse(input logic take);
      @(posedge mclk);
      if (take) engineTake <= 1'b1;
      else engineDone <= 1'b1;
      @(posedge mclk);
      {engineTake, engineDone} <= 2'b00;
   endtask : engPulse
   function automatic logic [7:0] therm(input int f);
      if (f == 16) return 8'h00;
      if (f >= 7) return 8'h01;
      return 8'hff >> f;
   endfunction : therm
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results

   // ****
   // scenarios
   // ****
   task automatic t_queue;
      int base;
      base = pCnt;
      engPulse(1'b1);
      for (int n = 0; n < 16; n++) begin
         bus(1'b1, 16'ha6e8, 16'h1230 + 16'(n));
         bus(1'b0, 16'h9ae8, 16'h0);
         chk(q[9] === 1'b1 && q[7:0] === therm(15 - n), "fill status");
      end
      chk(pCnt == base, "params applied mid command");
      bus(1'b1, 16'ha6e8, 16'hbeef);
      chk(w > 0 && engineHalt === 1'b1, "full write not stretched");
      bus(1'b0, 16'h42e8, 16'h0);
      chk(q[2] === 1'b1, "timeout flag");
      engPulse(1'b0);
      tick(20);
      chk(pCnt == base, "drained while halted");
      bus(1'b1, 16'h42e8, 16'h0004);
      chk(engineHalt === 1'b0, "halt kept");
      for (int i = 0; i < 300 && pCnt < base + 16; i++) tick(1);
      if (pCnt < base + 16) begin
         chk(1'b0, "queue never drained");
         results;
      end
      chk(pSel === 4'h9 && pData === 16'h123f, "queue exit");
      bus(1'b0, 16'h9ae8, 16'h0);
      chk(q[9] === 1'b0 && q[7:0] === 8'h00, "idle status");
      bus(1'b0, 16'h42e8, 16'h0);
      chk(q[3] === 1'b1, "idle flag");
      $display("done queue");
   endtask : t_queue
   task automatic t_pixel;
      bus(1'b0, 16'he2e8, 16'h0);
      chk(w > 0 && engineHalt === 1'b1, "empty read");
      bus(1'b1, 16'h42e8, 16'h0004);
      @(posedge mclk);
      readData <= 16'h5a3c;
      readDataValid <= 1'b1;
      @(posedge mclk);
      readDataValid <= 1'b0;
      readData <= 16'ha5c3;
      bus(1'b0, 16'h9ae8, 16'h0);
      chk(q[8] === 1'b1, "ready clear");
      bus(1'b0, 16'he2e8, 16'h0);
      chk(w == 0 && q === 16'h5a3c, "pixel word");
      bus(1'b0, 16'h9ae8, 16'h0);
      chk(q[8] === 1'b0, "ready stuck");
      $display("done pixel");
   endtask : t_pixel
   task automatic t_irq;
      int base;
      base = pCnt;
      bus(1'b1, 16'h42e8, 16'h0800);
      chk(irqOe === 1'b0 && pCnt == base, "stale irq or queued write");
      bus(1'b1, 16'h42e8, 16'h0100);
      @(posedge mclk);
      vblank <= 1'b1;
      tick(6);
      chk(irqOe === 1'b1 && irqOut === 1'b0, "mc irq");
      bus(1'b0, 16'h42e8, 16'h0);
      chk(q[0] === 1'b1 && q[11:8] === 4'h1, "vblank flag");
      @(posedge mclk);
      vblank <= 1'b0;
      scissorHit <= 1'b1;
      tick(2);
      bus(1'b0, 16'h42e8, 16'h0);
      chk(q[1] === 1'b0, "scissor hit with no command");
      scissorCmd <= 1'b1;
      tick(2);
      {scissorHit, scissorCmd} <= 2'b00;
      bus(1'b0, 16'h42e8, 16'h0);
      chk(q[1] === 1'b1, "scissor flag");
      bus(1'b1, 16'h42e8, 16'h0101);
      chk(irqOe === 1'b0, "irq after clear");
      $display("done irq");
   endtask : t_irq
   task automatic t_isa;
      @(posedge mclk);
      rst <= 1'b1;
      busTypeSelect_n <= 1'b0;
      tick(16);
      rst <= 1'b0;
      tick(4);
      chk(irqOe === 1'b0, "isa irq not floating");
      bus(1'b1, 16'h42e8, 16'h0100);
      chk(irqOe === 1'b1 && irqOut === 1'b0, "isa irq low");
      @(posedge mclk);
      vblank <= 1'b1;
      tick(6);
      chk(irqOut === 1'b1 && memCs16_n === 1'b1, "isa irq high");
      @(posedge mclk);
      vblank <= 1'b0;
      bus(1'b1, 16'h42e8, 16'h0101);
      chk(irqOe === 1'b1 && irqOut === 1'b0, "isa irq kept");
      $display("done isa");
   endtask : t_isa
   task automatic t_uisa;
      int base;
      base = pCnt;
      @(posedge mclk);
      rst <= 1'b1;
      unlatchedModeStrap <= 1'b0;
      tick(16);
      rst <= 1'b0;
      tick(4);
      mbus(1'b1, 24'h0a0010, 16'h7e81);
      tick(4);
      chk(w == 0 && zwsCnt > 0 && pCnt == base + 1, "pixel memory write");
      chk(pSel === 4'he && pData === 16'h7e81, "pixel memory entry");
      mbus(1'b0, 24'h0c8000, 16'h0);
      chk(romCnt > 0 && memCs16_n === 1'b1, "rom select");
      $display("done uisa");
   endtask : t_uisa

   initial begin
      tick(16);
      rst <= 1'b0;
      tick(4);
      chk(chanReady === 1'b1 && dataOe === 1'b0 && engineHalt === 1'b0, "reset outs");
      bus(1'b0, 16'h9ae8, 16'h0);
      chk(q[9:0] === 10'h000, "reset status");
      t_queue;
      t_pixel;
      t_irq;
      t_isa;
      t_uisa;
      results;
   end
endmodule : tb_host_bus_queue_irq
